/* shared/uep_cfg.svh */
// Offsets, field positions, reset values and counts for the endpoint-0 control block.
`ifndef UEP_CFG_SVH
`define UEP_CFG_SVH

`define UEP_OFF_DEV_CSR     8'h00
`define UEP_OFF_HOST_CSR    8'h04
`define UEP_OFF_IRQ_STAT    8'h08
`define UEP_OFF_IRQ_MASK    8'h0c
`define UEP_OFF_ROLE        8'h10

`define UEP_B_RX_ARRIVED    0
`define UEP_B_TX_LOADED     1
`define UEP_B_STALL_ISSUED  2
`define UEP_B_STALL_RCVD    2
`define UEP_B_LAST_MARK     3
`define UEP_B_SETUP_SEL     3
`define UEP_B_CTRL_ABORTED  4
`define UEP_B_ERROR         4
`define UEP_B_STALL_REQ     5
`define UEP_B_IN_REQ        5
`define UEP_B_RX_DONE_ACK   6
`define UEP_B_STATUS_SEL    6
`define UEP_B_EARLY_END_ACK 7
`define UEP_B_NAK_LIMIT     7
`define UEP_B_PURGE         8
`define UEP_B_TOGGLE        9
`define UEP_B_TOGGLE_UNLOCK 10
`define UEP_B_PING_SUPPRESS 11

`define UEP_I_RX            0
`define UEP_I_TX            1
`define UEP_I_ABORT         2
`define UEP_I_ERROR         3
`define UEP_I_STALL         4
`define UEP_I_NAK           5

`define UEP_IRQ_ALWAYS      6'h0d
`define UEP_RST_MASK        6'h00
`define UEP_RST_WORD        16'h0000
`define UEP_RETRY_LIMIT     2'h3

`endif

/* shared/uep_pkg.sv */
// Types shared by the endpoint-0 control block.
package uep_pkg;
  typedef logic [15:0] uep_word_t;
  typedef logic [7:0]  uep_addr_t;
  typedef logic [5:0]  uep_ivec_t;
  typedef enum logic {UEP_ROLE_DEV = 1'b0, UEP_ROLE_HOST = 1'b1} uep_role_t;
endpackage

/* shared/uep_evt_if.sv */
// Event and interrupt register signals between the core and the interrupt unit.
`timescale 1ns/1ns
`default_nettype none
interface uep_evt_if;
  import uep_pkg::*;
  uep_ivec_t evt;
  logic      stat_wr;
  logic      mask_wr;
  uep_ivec_t wdata;
  uep_ivec_t stat;
  uep_ivec_t mask;
  logic      irq;
  modport core (output evt, stat_wr, mask_wr, wdata, input stat, mask, irq);
  modport unit (input evt, stat_wr, mask_wr, wdata, output stat, mask, irq);
endinterface
`default_nettype wire

/* logic/uep_irq.sv */
// Sticky interrupt status, mask and level interrupt output.
`include "uep_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module uep_irq
  import uep_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  uep_evt_if.unit   ev
);
  uep_ivec_t stat_q, stat_d, mask_q, mask_d;
  logic      irq_q, irq_d;

  // Events win over a write-one clear in the same cycle.
  always_comb
  begin
    stat_d = (stat_q & ~(ev.stat_wr ? ev.wdata : 6'h00)) | ev.evt;
    mask_d = ev.mask_wr ? ev.wdata : mask_q;
    irq_d  = |(stat_d & (mask_d | `UEP_IRQ_ALWAYS));
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      stat_q <= 6'h00;
      mask_q <= `UEP_RST_MASK;
      irq_q  <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q  <= irq_d;
    end
  end

  assign ev.stat = stat_q;
  assign ev.mask = mask_q;
  assign ev.irq  = irq_q;
endmodule
`default_nettype wire

/* logic/uep_retry.sv */
// Counts unanswered host attempts and flags an error after the limit.
`include "uep_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module uep_retry
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic no_resp_i,
  input  wire logic resp_i,
  output logic      err_o
);
  logic [1:0] cnt_q, cnt_d;
  logic       err_q, err_d;

  always_comb
  begin
    cnt_d = cnt_q;
    err_d = 1'b0;
    if (resp_i)
    begin
      cnt_d = 2'h0;
    end
    else if (no_resp_i)
    begin
      if (cnt_q == `UEP_RETRY_LIMIT - 2'h1)
      begin
        cnt_d = 2'h0;
        err_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 2'h0;
      err_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      err_q <= err_d;
    end
  end

  assign err_o = err_q;
endmodule
`default_nettype wire

/* logic/uep_ep0_ctrl.sv */
// Endpoint-0 control and status registers for device and host roles.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`include "uep_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Purge drops next packet, clears ready flag.
// - Early-end acknowledge clears control-aborted flag.
// - Receive-done acknowledge clears received flag.
// - Stall request sends STALL, then self-clears.
// - Early control end: aborted flag, interrupt, flush.
// - Sent STALL sets sticky stall-issued flag.
// - Transmit-loaded cleared when sent, optional interrupt.
// - Arrived packet sets received flag, interrupts.
// - Ping suppress stops PING in control stages.
// - Unlock bit permits toggle write, self-clears.
// - Toggle reads current state; locked writes ignored.
// - NAK limit halts endpoint until cleared.
// - Status stage select forces DATA1 toggle.
// - IN request cleared when packet arrives.
// - Three unanswered attempts set error, interrupt.
// - Setup select sends SETUP instead of OUT.
// - Received STALL sets sticky stall-received flag.
module uep_ep0_ctrl
  import uep_pkg::*;
(
  input  wire logic            clock_i,
  input  wire logic            rst_i,
  input  wire uep_pkg::uep_addr_t addr_i,
  input  wire uep_pkg::uep_word_t wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output uep_pkg::uep_word_t   rdata_o,
  output logic                 irq_o,
  input  wire logic            pe_tx_sent_i,
  input  wire logic            pe_rx_pkt_i,
  input  wire logic            pe_stall_sent_i,
  input  wire logic            pe_xfer_end_i,
  input  wire logic            pe_stall_rcvd_i,
  input  wire logic            pe_nak_limit_i,
  input  wire logic            pe_no_resp_i,
  input  wire logic            pe_resp_i,
  input  wire logic            pe_toggle_flip_i,
  output logic                 eng_host_o,
  output logic                 eng_tx_ready_o,
  output logic                 eng_in_req_o,
  output logic                 eng_setup_o,
  output logic                 eng_status_o,
  output logic                 eng_no_ping_o,
  output logic                 eng_stall_o,
  output logic                 eng_last_o,
  output logic                 eng_toggle_o,
  output logic                 eng_halt_o,
  output logic                 eng_flush_o
);
  import uep_pkg::*;

  uep_evt_if ev ();

  // Next value of a flag that one source sets and another clears; set wins.
  function automatic logic flag_next(input logic q, input logic set, input logic clr);
    flag_next = set | (q & ~clr);
  endfunction

  // Write strobe for one register offset.
  function automatic logic hit(input uep_addr_t a, input uep_addr_t off, input logic s);
    hit = s && (a == off);
  endfunction

  uep_role_t role_q, role_d;
  logic tx_q, tx_d, rx_q, rx_d, abort_q, abort_d, last_q, last_d;
  logic sissued_q, sissued_d, sreq_q, sreq_d;
  logic ping_q, ping_d, tog_q, tog_d, status_q, status_d;
  logic inreq_q, inreq_d, err_q, err_d, setup_q, setup_d, srcvd_q, srcvd_d;
  logic nak_q, nak_d, flush_q, flush_d;
  uep_word_t rdata_q, rdata_d;
  logic dev, host, wdev, whost, purge, purge_tx, purge_rx, early_end, retry_err;
  uep_ivec_t evt;

  uep_retry u_retry (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .no_resp_i (pe_no_resp_i && host),
    .resp_i    (pe_resp_i || !host),
    .err_o     (retry_err)
  );

  uep_irq u_irq (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ev      (ev)
  );

  always_comb
  begin
    dev       = (role_q == UEP_ROLE_DEV);
    host      = (role_q == UEP_ROLE_HOST);
    wdev      = hit(addr_i, `UEP_OFF_DEV_CSR, wr_i) && dev;
    whost     = hit(addr_i, `UEP_OFF_HOST_CSR, wr_i) && host;
    purge     = (wdev || whost) && wdata_i[`UEP_B_PURGE];
    purge_tx  = purge && tx_q;
    purge_rx  = purge && !tx_q && rx_q;
    early_end = dev && pe_xfer_end_i && !last_q;
  end

  always_comb
  begin
    role_d = role_q;
    if (hit(addr_i, `UEP_OFF_ROLE, wr_i))
    begin
      role_d = uep_role_t'(wdata_i[0]);
    end
  end

  // Device-view flags, shared ready flags and the flush pulse.
  always_comb
  begin
    // Transmit-loaded: software sets, send, purge or abort clears.
    tx_d = flag_next(tx_q, (wdev || whost) && wdata_i[`UEP_B_TX_LOADED],
                     pe_tx_sent_i || purge_tx || early_end);
    // Received flag: the arriving packet wins over any clear.
    rx_d = flag_next(rx_q, pe_rx_pkt_i,
                     purge_rx
                     || (wdev && wdata_i[`UEP_B_RX_DONE_ACK])
                     || (whost && !wdata_i[`UEP_B_RX_ARRIVED]));
    abort_d = flag_next(abort_q, early_end,
                        wdev && wdata_i[`UEP_B_EARLY_END_ACK]);
    last_d = flag_next(last_q, wdev && wdata_i[`UEP_B_LAST_MARK],
                       pe_tx_sent_i || pe_xfer_end_i);
    sissued_d = flag_next(sissued_q, dev && pe_stall_sent_i,
                          wdev && !wdata_i[`UEP_B_STALL_ISSUED]);
    sreq_d = flag_next(sreq_q, wdev && wdata_i[`UEP_B_STALL_REQ],
                       pe_stall_sent_i);
    flush_d = purge_tx || purge_rx || early_end;
  end

  // Host-view flags.
  always_comb
  begin
    ping_d = whost ? wdata_i[`UEP_B_PING_SUPPRESS] : ping_q;
    tog_d = tog_q;
    if (pe_toggle_flip_i)
    begin
      tog_d = !tog_q;
    end
    if (whost && wdata_i[`UEP_B_TOGGLE_UNLOCK])
    begin
      tog_d = wdata_i[`UEP_B_TOGGLE];
    end
    if (whost && wdata_i[`UEP_B_STATUS_SEL]
        && (wdata_i[`UEP_B_TX_LOADED] || wdata_i[`UEP_B_IN_REQ]))
    begin
      tog_d = 1'b1;
    end
    status_d = flag_next(status_q, whost && wdata_i[`UEP_B_STATUS_SEL],
                         pe_tx_sent_i || pe_rx_pkt_i
                         || (whost && !wdata_i[`UEP_B_STATUS_SEL]));
    inreq_d = flag_next(inreq_q & ~(host && pe_rx_pkt_i),
                        whost && wdata_i[`UEP_B_IN_REQ] && !pe_rx_pkt_i,
                        whost && !wdata_i[`UEP_B_IN_REQ]);
    err_d = flag_next(err_q, retry_err,
                      whost && !wdata_i[`UEP_B_ERROR]);
    setup_d = flag_next(setup_q, whost && wdata_i[`UEP_B_SETUP_SEL],
                        pe_tx_sent_i
                        || (whost && !wdata_i[`UEP_B_SETUP_SEL]));
    srcvd_d = flag_next(srcvd_q, host && pe_stall_rcvd_i,
                        whost && !wdata_i[`UEP_B_STALL_RCVD]);
    nak_d = flag_next(nak_q, host && pe_nak_limit_i,
                      whost && !wdata_i[`UEP_B_NAK_LIMIT]);
  end

  // Interrupt events and software access to the interrupt registers.
  always_comb
  begin
    evt                = 6'h00;
    evt[`UEP_I_RX]     = pe_rx_pkt_i;
    evt[`UEP_I_TX]     = tx_q && pe_tx_sent_i;
    evt[`UEP_I_ABORT]  = early_end;
    evt[`UEP_I_ERROR]  = retry_err;
    evt[`UEP_I_STALL]  = (dev && pe_stall_sent_i) || (host && pe_stall_rcvd_i);
    evt[`UEP_I_NAK]    = host && pe_nak_limit_i;
    ev.evt     = evt;
    ev.stat_wr = hit(addr_i, `UEP_OFF_IRQ_STAT, wr_i);
    ev.mask_wr = hit(addr_i, `UEP_OFF_IRQ_MASK, wr_i);
    ev.wdata   = wdata_i[5:0];
  end

  // Read data for the cycle after the read strobe.
  always_comb
  begin
    rdata_d = `UEP_RST_WORD;
    if (rd_i)
    begin
      case (addr_i)
        `UEP_OFF_DEV_CSR:
        begin
          rdata_d[`UEP_B_RX_ARRIVED]   = rx_q;
          rdata_d[`UEP_B_TX_LOADED]    = tx_q;
          rdata_d[`UEP_B_STALL_ISSUED] = sissued_q;
          rdata_d[`UEP_B_CTRL_ABORTED] = abort_q;
        end
        `UEP_OFF_HOST_CSR:
        begin
          rdata_d[`UEP_B_RX_ARRIVED]    = rx_q;
          rdata_d[`UEP_B_TX_LOADED]     = tx_q;
          rdata_d[`UEP_B_STALL_RCVD]    = srcvd_q;
          rdata_d[`UEP_B_SETUP_SEL]     = setup_q;
          rdata_d[`UEP_B_ERROR]         = err_q;
          rdata_d[`UEP_B_IN_REQ]        = inreq_q;
          rdata_d[`UEP_B_STATUS_SEL]    = status_q;
          rdata_d[`UEP_B_NAK_LIMIT]     = nak_q;
          rdata_d[`UEP_B_TOGGLE]        = tog_q;
          rdata_d[`UEP_B_PING_SUPPRESS] = ping_q;
        end
        `UEP_OFF_IRQ_STAT: rdata_d[5:0] = ev.stat;
        `UEP_OFF_IRQ_MASK: rdata_d[5:0] = ev.mask;
        `UEP_OFF_ROLE:     rdata_d[0]   = role_q;
        default:           rdata_d      = `UEP_RST_WORD;
      endcase
    end
  end

  // Role and flush pulse registers.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      role_q  <= UEP_ROLE_DEV;
      flush_q <= 1'b0;
    end
    else
    begin
      role_q  <= role_d;
      flush_q <= flush_d;
    end
  end

  // Read data register.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rdata_q <= `UEP_RST_WORD;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // Device-view and shared flag registers.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tx_q      <= 1'b0;
      rx_q      <= 1'b0;
      abort_q   <= 1'b0;
      last_q    <= 1'b0;
      sissued_q <= 1'b0;
      sreq_q    <= 1'b0;
    end
    else
    begin
      tx_q      <= tx_d;
      rx_q      <= rx_d;
      abort_q   <= abort_d;
      last_q    <= last_d;
      sissued_q <= sissued_d;
      sreq_q    <= sreq_d;
    end
  end

  // Host-view flag registers.
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ping_q   <= 1'b0;
      tog_q    <= 1'b0;
      status_q <= 1'b0;
      inreq_q  <= 1'b0;
      err_q    <= 1'b0;
      setup_q  <= 1'b0;
      srcvd_q  <= 1'b0;
      nak_q    <= 1'b0;
    end
    else
    begin
      ping_q   <= ping_d;
      tog_q    <= tog_d;
      status_q <= status_d;
      inreq_q  <= inreq_d;
      err_q    <= err_d;
      setup_q  <= setup_d;
      srcvd_q  <= srcvd_d;
      nak_q    <= nak_d;
    end
  end

  // Engine controls all come from flops.
  assign rdata_o        = rdata_q;
  assign irq_o          = ev.irq;
  assign eng_host_o     = role_q;
  assign eng_tx_ready_o = tx_q;
  assign eng_in_req_o   = inreq_q;
  assign eng_setup_o    = setup_q;
  assign eng_status_o   = status_q;
  assign eng_no_ping_o  = ping_q;
  assign eng_stall_o    = sreq_q;
  assign eng_last_o     = last_q;
  assign eng_toggle_o   = tog_q;
  assign eng_halt_o     = nak_q;
  assign eng_flush_o    = flush_q;
endmodule
`default_nettype wire

/* tb/uep_ep0_ctrl_chk.sv */
// Port assertions for the endpoint-0 control block.
`timescale 1ns/1ns
`default_nettype none
module uep_ep0_ctrl_chk
(
  input wire logic               clock_i,
  input wire logic               rst_i,
  input wire uep_pkg::uep_addr_t addr_i,
  input wire uep_pkg::uep_word_t wdata_i,
  input wire logic               wr_i,
  input wire logic               rd_i,
  input wire uep_pkg::uep_word_t rdata_o,
  input wire logic               irq_o,
  input wire logic               pe_tx_sent_i,
  input wire logic               pe_rx_pkt_i,
  input wire logic               pe_stall_sent_i,
  input wire logic               pe_xfer_end_i,
  input wire logic               pe_no_resp_i,
  input wire logic               eng_host_o,
  input wire logic               eng_tx_ready_o,
  input wire logic               eng_stall_o,
  input wire logic               eng_last_o,
  input wire logic               eng_toggle_o,
  input wire logic               eng_flush_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_abort;
    pe_xfer_end_i && !eng_last_o && !eng_host_o;
  endsequence
  sequence s_flush_irq;
    eng_flush_o ##1 irq_o;
  endsequence
  sequence s_miss3;
    (eng_host_o && pe_no_resp_i) [*3];
  endsequence
  a_read_slot: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data outside read slot");
  a_rx_irq: assert property (pe_rx_pkt_i |-> ##2 irq_o)
    else $error("no interrupt after packet arrival");
  a_abort_flush: assert property (s_abort |=> s_flush_irq)
    else $error("early end without flush and interrupt");
  a_stall_clear: assert property (eng_stall_o && pe_stall_sent_i && !wr_i |=> !eng_stall_o)
    else $error("stall request kept after stall sent");
  a_tx_clear: assert property (pe_tx_sent_i && !wr_i |=> !eng_tx_ready_o)
    else $error("transmit flag kept after send");
  a_mark_clear: assert property ((pe_tx_sent_i || pe_xfer_end_i) && !wr_i |=> !eng_last_o)
    else $error("last mark kept");
  a_retry_err: assert property (s_miss3 |-> ##[1:4] irq_o)
    else $error("no interrupt after three misses");
  a_status_tog: assert property (eng_host_o && wr_i && addr_i == 8'h04 && wdata_i[6]
    && (wdata_i[1] || wdata_i[5]) |=> eng_toggle_o)
    else $error("status stage without toggle one");
endmodule
`default_nettype wire

/* tb/uep_far_model.sv */
// Far-side engine model that completes pending transmit and IN work after a delay.
`timescale 1ns/1ns
`default_nettype none
module uep_far_model
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire logic [2:0] dly_i,
  input  wire logic       push_i,
  input  wire logic       tx_ready_i,
  input  wire logic       in_req_i,
  input  wire logic       halt_i,
  output logic            tx_sent_o,
  output logic            rx_pkt_o
);
  logic [2:0] cnt;
  always @(posedge clock_i)
  begin
    tx_sent_o <= 1'b0;
    rx_pkt_o  <= push_i;
    if (rst_i || !en_i || halt_i || tx_sent_o || rx_pkt_o || !(tx_ready_i || in_req_i))
      cnt <= 3'h0;
    else if (cnt == dly_i)
    begin
      cnt       <= 3'h0;
      tx_sent_o <= tx_ready_i;
      rx_pkt_o  <= !tx_ready_i;
    end
    else
      cnt <= cnt + 3'h1;
  end
endmodule
`default_nettype wire

/* tb/usb_ep0_control_status_tb.sv */
// Self-checking bench for the endpoint-0 control block.
`timescale 1ns/1ns
`default_nettype none
module usb_ep0_control_status_tb;
  import uep_pkg::*;
  localparam logic [7:0] EV_T [7] = '{8'h08, 8'h04, 8'h10, 8'h20, 8'h10, 8'h10, 8'h40};
  localparam int         N_T [7]  = '{1, 1, 2, 1, 1, 3, 1};
  localparam uep_word_t  X_T [7]  = '{16'h0080, 16'h0004, 16'h0000, 16'h0000, 16'h0000,
                                      16'h0010, 16'h0200};
  logic        clock_i;
  logic        rst_i;
  uep_addr_t   addr_i;
  uep_word_t   wdata_i;
  logic        wr_i;
  logic        rd_i;
  uep_word_t   rdata_o;
  logic        irq_o;
  logic        tx_sent;
  logic        rx_pkt;
  logic        en;
  logic [2:0]  dly;
  logic [7:0]  ev;
  wire  [10:0] eng;
  logic        rd_pend;
  uep_word_t   hv;
  uep_word_t   exp_q [$];
  int          errors;
  int          samples_checked;
  int          cycles;
  uep_ep0_ctrl uep_ep0_ctrl_inst (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .pe_tx_sent_i(tx_sent), .pe_rx_pkt_i(rx_pkt), .pe_stall_sent_i(ev[0]),
    .pe_xfer_end_i(ev[1]), .pe_stall_rcvd_i(ev[2]), .pe_nak_limit_i(ev[3]),
    .pe_no_resp_i(ev[4]), .pe_resp_i(ev[5]), .pe_toggle_flip_i(ev[6]),
    .eng_host_o(eng[0]), .eng_tx_ready_o(eng[1]), .eng_in_req_o(eng[2]), .eng_setup_o(eng[3]),
    .eng_status_o(eng[4]), .eng_no_ping_o(eng[5]), .eng_stall_o(eng[6]), .eng_last_o(eng[7]),
    .eng_toggle_o(eng[8]), .eng_halt_o(eng[9]), .eng_flush_o(eng[10]));
  uep_far_model uep_far_model_inst (.clock_i(clock_i), .rst_i(rst_i), .en_i(en), .dly_i(dly),
    .push_i(ev[7]), .tx_ready_i(eng[1]), .in_req_i(eng[2]), .halt_i(eng[9]),
    .tx_sent_o(tx_sent), .rx_pkt_o(rx_pkt));
  task automatic give_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string n, input uep_word_t e, input uep_word_t g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input uep_addr_t a, input uep_word_t d);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input uep_addr_t a, input uep_word_t e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
  endtask
  task automatic pulse(input logic [7:0] v, input int n);
    @(posedge clock_i);
    ev <= v;
    repeat (n) @(posedge clock_i);
    ev <= 8'h00;
    repeat (3) @(posedge clock_i);
    #1;
  endtask
  task automatic wait_done(input int b);
    for (int k = 0; k < 40 && eng[b] === 1'b1; k++)
      @(posedge clock_i) #1;
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    if (rd_pend)
      check("rdata", exp_q.pop_front(), rdata_o);
    rd_pend <= rd_i;
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      give_verdict();
    end
  end
  initial
  begin
    rst_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    en = 1'b0;
    dly = 3'h0;
    ev = 8'h00;
    rd_pend = 1'b0;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    void'($urandom(30));
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(8'h00, 16'h0000);
    rd(8'h14, 16'h0000);
    pulse(8'h80, 1);
    rd(8'h00, 16'h0001);
    check("irq", 16'h0001, irq_o);
    wr(8'h00, 16'h0040);
    rd(8'h00, 16'h0000);
    wr(8'h08, 16'h003f);
    wr(8'h00, 16'h0100);
    check("flush", 16'h0000, eng[10]);
    wr(8'h00, 16'h0002);
    rd(8'h00, 16'h0002);
    wr(8'h00, 16'h0100);
    check("flush", 16'h0001, eng[10]);
    rd(8'h00, 16'h0000);
    for (int m = 0; m < 2; m++)
    begin
      wr(8'h0c, m ? 16'h0002 : 16'h0000);
      dly <= 3'($urandom);
      en <= 1'b1;
      wr(8'h00, 16'h000a);
      wait_done(1);
      en <= 1'b0;
      check("irq", 16'(m), irq_o);
      check("last", 16'h0000, eng[7]);
      rd(8'h00, 16'h0000);
      wr(8'h08, 16'h003f);
    end
    wr(8'h00, 16'h0020);
    check("stall", 16'h0001, eng[6]);
    pulse(8'h01, 1);
    check("stall", 16'h0000, eng[6]);
    rd(8'h00, 16'h0004);
    wr(8'h00, 16'h0000);
    rd(8'h00, 16'h0000);
    wr(8'h00, 16'h0008);
    pulse(8'h02, 1);
    rd(8'h00, 16'h0000);
    pulse(8'h02, 1);
    check("irq", 16'h0001, irq_o);
    rd(8'h00, 16'h0010);
    wr(8'h00, 16'h0080);
    rd(8'h00, 16'h0000);
    wr(8'h08, 16'h003f);
    wr(8'h10, 16'h0001);
    wr(8'h04, {4'($urandom), 12'he00});
    check("no_ping", 16'h0001, eng[5]);
    rd(8'h04, 16'h0a00);
    wr(8'h04, 16'h0800);
    rd(8'h04, 16'h0a00);
    wr(8'h04, 16'h0c00);
    rd(8'h04, 16'h0800);
    wr(8'h04, 16'h0842);
    check("toggle", 16'h0001, eng[8]);
    check("status", 16'h0001, eng[4]);
    en <= 1'b1;
    wait_done(1);
    rd(8'h04, 16'h0a00);
    en <= 1'b0;
    wr(8'h04, 16'h080a);
    check("setup", 16'h0001, eng[3]);
    en <= 1'b1;
    wait_done(1);
    wr(8'h04, 16'h0820);
    check("in_req", 16'h0001, eng[2]);
    wait_done(2);
    rd(8'h04, 16'h0a01);
    wr(8'h04, 16'h0800);
    hv = 16'h0a00;
    for (int i = 0; i < 7; i++)
    begin
      pulse(EV_T[i], N_T[i]);
      hv = hv ^ X_T[i];
      rd(8'h04, hv);
    end
    check("halt", 16'h0001, eng[9]);
    wr(8'h04, 16'h0800);
    check("halt", 16'h0000, eng[9]);
    rd(8'h04, 16'h0800);
    repeat (3) @(posedge clock_i);
    give_verdict();
  end
endmodule
bind uep_ep0_ctrl uep_ep0_ctrl_chk uep_ep0_ctrl_chk_inst (.clock_i(clock_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .irq_o(irq_o), .pe_tx_sent_i(pe_tx_sent_i), .pe_rx_pkt_i(pe_rx_pkt_i),
  .pe_stall_sent_i(pe_stall_sent_i), .pe_xfer_end_i(pe_xfer_end_i),
  .pe_no_resp_i(pe_no_resp_i), .eng_host_o(eng_host_o), .eng_tx_ready_o(eng_tx_ready_o),
  .eng_stall_o(eng_stall_o), .eng_last_o(eng_last_o), .eng_toggle_o(eng_toggle_o),
  .eng_flush_o(eng_flush_o));
`default_nettype wire
